/* hw/csst_pkg.sv */
// Package: constants and carrier types for the clock switch and system timers
package csst_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS     = 4;
    localparam int XTAL_TIMEOUT_NS   = 200;
    localparam int XTAL_TIMEOUT_CYC  = XTAL_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int REF_TICK_MS       = 1;
    localparam int WDOG_EXPIRE_MS    = 2048;
    localparam int WDOG_WARN_MS      = 1792;
    localparam int WDOG_EXPIRE_TICKS = WDOG_EXPIRE_MS / REF_TICK_MS;
    localparam int WDOG_WARN_TICKS   = WDOG_WARN_MS / REF_TICK_MS;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] ADDR_CLK_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_CLK_STATUS = 8'h04;
    localparam logic [7:0] ADDR_REF_DIV    = 8'h08;
    localparam logic [7:0] ADDR_WDOG_CTRL  = 8'h0C;
    localparam logic [7:0] ADDR_WDOG_COUNT = 8'h10;
    localparam logic [7:0] ADDR_SLP_CTRL   = 8'h14;
    localparam logic [7:0] ADDR_SLP_COUNT  = 8'h18;
    localparam logic [7:0] ADDR_SLP_CMP_A  = 8'h1C;
    localparam logic [7:0] ADDR_SLP_CMP_B  = 8'h20;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CTRL_SRC_BIT   = 0;
    localparam int CTRL_CPU_BIT   = 1;
    localparam int CTRL_BIAS_LSB  = 4;
    localparam int CTRL_DIG_BIT   = 8;
    localparam int CTRL_EVT_BIT   = 9;
    localparam int STAT_SRC_BIT   = 0;
    localparam int STAT_FAIL_BIT  = 1;
    localparam int STAT_FLASH_BIT = 2;
    localparam int WDOG_EN_BIT    = 0;
    localparam int WDOG_RST_BIT   = 1;
    localparam int SLP_SRC_BIT    = 0;
    localparam int SLP_EXP_LSB    = 4;
    localparam int SLP_DBG_BIT    = 8;
    localparam int SLP_IRQ_LSB    = 12;
    localparam int SLP_WAKE_LSB   = 16;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [3:0]  BIAS_RST    = 4'hF;
    localparam logic [15:0] REF_INC_RST = 16'h199A;
    localparam logic [3:0]  SLP_EXP_RST = 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } csst_bus_type;

    typedef struct packed {
        logic fast_rc;
        logic fast_xtal;
        logic slow_rc;
        logic slow_xtal;
        logic slow_pin;
    } csst_osc_type;

    typedef struct packed {
        logic main_clock;
        logic periph_clock;
        logic cpu_core_clock;
        logic reference_tick_1khz;
        logic sleep_tick;
        logic event_tick_timer;
    } csst_clk_type;

endpackage

/* hw/csst_wdog.sv */
// Watchdog counting the 1 kHz reference tick
module csst_wdog #(
    parameter int CNT_W = 12
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             tick,
    input  wire logic             enable,
    input  wire logic             restart,
    input  wire logic             dbg_halt,
    output logic [CNT_W-1:0]      count,
    output logic                  warn_nmi,
    output logic                  wdog_reset
);
    import csst_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             warn;
        logic             rst_p;
    } csst_wd_state_type;

    csst_wd_state_type s_reg;
    csst_wd_state_type s_next;

    always_comb
    begin
        s_next       = s_reg;
        s_next.warn  = 1'b0;
        s_next.rst_p = 1'b0;
        if (!enable)
        begin
            s_next.cnt = '0;
        end
        else if (restart)
        begin
            s_next.cnt = '0;
        end
        else if (tick && !dbg_halt)
        begin
            if (s_reg.cnt == CNT_W'(WDOG_EXPIRE_TICKS - 1))
            begin
                s_next.cnt   = '0;
                s_next.rst_p = 1'b1;
            end
            else
            begin
                s_next.cnt = s_reg.cnt + 1'b1;
                if (s_reg.cnt == CNT_W'(WDOG_WARN_TICKS - 1))
                begin
                    s_next.warn = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign count      = s_reg.cnt;
    assign warn_nmi   = s_reg.warn;
    assign wdog_reset = s_reg.rst_p;

    chk_wd_expire: assert property (@(posedge clk) disable iff (sys_rst)
        enable && !restart && tick && !dbg_halt
            && count == CNT_W'(WDOG_EXPIRE_TICKS - 1)
        |=> wdog_reset && count == '0)
        else $error("watchdog did not expire at full count");

    chk_wd_warn: assert property (@(posedge clk) disable iff (sys_rst)
        warn_nmi |-> count == CNT_W'(WDOG_WARN_TICKS) && $past(count) != count)
        else $error("watchdog warning at wrong count");

    chk_wd_pause: assert property (@(posedge clk) disable iff (sys_rst)
        enable && !restart && dbg_halt |=> $stable(count))
        else $error("watchdog counted while halted");

    chk_wd_off: assert property (@(posedge clk) disable iff (sys_rst)
        !enable |=> count == '0 && !wdog_reset)
        else $error("disabled watchdog is counting");

endmodule

/* hw/csst_top.sv */
// Clock source switch, reference divider, watchdog and sleep timer
// Operation
// - Crystal failure falls back to RC source
// - Failover raises a non-maskable interrupt pulse
// - RC oscillator is selected after reset
// - Select bit picks RC or crystal main
// - Peripheral clock is half the main clock
// - CPU select bit picks peripheral or main
// - Flash activity forces CPU clock to 12MHz
// - Fractional divider makes 1 kHz from 10 kHz
// - Crystal bias is software programmable
// - Slow path accepts digital clock on pin
// - Watchdog disabled at power up
// - Watchdog expires after 2048 ticks, resets
// - Warning interrupt at 1792 ticks
// - Watchdog pauses while debugger halts CPU
// - Sleep timer uses 1 kHz or slow crystal
// - Power-of-two prescaler before sleep counter
// - Compares and wrap raise irq or wake
// - Sleep timer runs on halt by default
// - Sleep timer stops without slow clocks
// - Event tick clock is CPU or sleep
module csst_top (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire csst_pkg::csst_bus_type bus,
    output logic [31:0]                rdata,
    input  wire csst_pkg::csst_osc_type osc,
    input  wire logic                  flash_busy,
    input  wire logic                  dbg_halt,
    input  wire logic                  slow_rc_off,
    output csst_pkg::csst_clk_type     clk_out,
    output logic [3:0]                 crystal_bias,
    output logic                       failover_nmi,
    output logic                       wdog_warn_nmi,
    output logic                       wdog_reset,
    output logic                       sleep_irq,
    output logic                       sleep_wake
);
    import csst_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic        src_xtal;
        logic        sel_xtal;
        logic        cpu_fast;
        logic        cpu_fast_act;
        logic        flash_act;
        logic        phase;
        logic [3:0]  bias;
        logic        slow_dig;
        logic        evt_sel;
        logic        fail_flag;
        logic        nmi_fail;
        logic [7:0]  fail_cnt;
        logic [15:0] ref_inc;
        logic [15:0] ref_acc;
        logic        ref_tick;
        logic        wd_en;
        logic        wd_restart;
        logic        st_src;
        logic [3:0]  st_exp;
        logic        st_dbg;
        logic [2:0]  st_irq_en;
        logic [2:0]  st_wake_en;
        logic [15:0] st_pre;
        logic [31:0] st_cnt;
        logic [31:0] cmp_a;
        logic [31:0] cmp_b;
        logic        st_tick;
        logic        st_irq;
        logic        st_wake;
        logic [31:0] rdata;
    } csst_state_type;

    csst_state_type s_reg;
    csst_state_type s_next;

    logic [11:0] wd_count;
    logic        main_en;
    logic        periph_en;
    logic        cpu_en;
    logic        cpu_12m;
    logic        boundary;
    logic        rc_tick;
    logic        slow_tick;
    logic        st_src_tick;
    logic        st_run;
    logic [2:0]  st_ev;
    logic [16:0] ref_sum;
    logic [31:0] st_inc;

    function automatic logic [15:0] pre_mask(input logic [3:0] exp);
        pre_mask = (16'h0001 << exp) - 16'h0001;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Clock enables

    assign main_en   = s_reg.src_xtal ? osc.fast_xtal : osc.fast_rc;
    assign periph_en = main_en & s_reg.phase;
    // 12 MHz is the main clock on RC and the peripheral clock on crystal
    assign cpu_12m   = s_reg.src_xtal ? periph_en : main_en;
    assign cpu_en    = s_reg.flash_act ? cpu_12m
                     : (s_reg.cpu_fast_act ? main_en : periph_en);
    // Requested switches happen only between peripheral periods so no pulse is cut short; failover switches at once
    assign boundary  = ~s_reg.phase & ~main_en;

    assign rc_tick     = osc.slow_rc & ~slow_rc_off;
    assign slow_tick   = s_reg.slow_dig ? osc.slow_pin : osc.slow_xtal;
    assign st_src_tick = s_reg.st_src ? slow_tick : s_reg.ref_tick;
    assign st_run      = ~(dbg_halt & s_reg.st_dbg);
    assign ref_sum     = {1'b0, s_reg.ref_acc} + {1'b0, s_reg.ref_inc};
    assign st_inc      = s_reg.st_cnt + 32'h00000001;
    assign st_ev       = {&s_reg.st_cnt,
                          st_inc == s_reg.cmp_b,
                          st_inc == s_reg.cmp_a};

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        s_next            = s_reg;
        s_next.nmi_fail   = 1'b0;
        s_next.ref_tick   = 1'b0;
        s_next.st_tick    = 1'b0;
        s_next.st_irq     = 1'b0;
        s_next.st_wake    = 1'b0;
        s_next.wd_restart = 1'b0;
        s_next.rdata      = '0;

        // Register writes
        if (bus.wr)
        begin
            if (bus.addr == ADDR_CLK_CTRL)
            begin
                s_next.sel_xtal = bus.wdata[CTRL_SRC_BIT];
                s_next.cpu_fast = bus.wdata[CTRL_CPU_BIT];
                s_next.bias     = bus.wdata[CTRL_BIAS_LSB +: 4];
                s_next.slow_dig = bus.wdata[CTRL_DIG_BIT];
                s_next.evt_sel  = bus.wdata[CTRL_EVT_BIT];
            end
            else if (bus.addr == ADDR_CLK_STATUS)
            begin
                if (bus.wdata[STAT_FAIL_BIT])
                begin
                    s_next.fail_flag = 1'b0;
                end
            end
            else if (bus.addr == ADDR_REF_DIV)
            begin
                s_next.ref_inc = bus.wdata[15:0];
            end
            else if (bus.addr == ADDR_WDOG_CTRL)
            begin
                s_next.wd_en      = bus.wdata[WDOG_EN_BIT];
                s_next.wd_restart = bus.wdata[WDOG_RST_BIT];
            end
            else if (bus.addr == ADDR_SLP_CTRL)
            begin
                s_next.st_src     = bus.wdata[SLP_SRC_BIT];
                s_next.st_exp     = bus.wdata[SLP_EXP_LSB +: 4];
                s_next.st_dbg     = bus.wdata[SLP_DBG_BIT];
                s_next.st_irq_en  = bus.wdata[SLP_IRQ_LSB +: 3];
                s_next.st_wake_en = bus.wdata[SLP_WAKE_LSB +: 3];
            end
            else if (bus.addr == ADDR_SLP_CMP_A)
            begin
                s_next.cmp_a = bus.wdata;
            end
            else if (bus.addr == ADDR_SLP_CMP_B)
            begin
                s_next.cmp_b = bus.wdata;
            end
        end

        // Register reads, answered in the next cycle
        if (bus.rd)
        begin
            if (bus.addr == ADDR_CLK_CTRL)
            begin
                s_next.rdata[CTRL_SRC_BIT]       = s_reg.sel_xtal;
                s_next.rdata[CTRL_CPU_BIT]       = s_reg.cpu_fast;
                s_next.rdata[CTRL_BIAS_LSB +: 4] = s_reg.bias;
                s_next.rdata[CTRL_DIG_BIT]       = s_reg.slow_dig;
                s_next.rdata[CTRL_EVT_BIT]       = s_reg.evt_sel;
            end
            else if (bus.addr == ADDR_CLK_STATUS)
            begin
                s_next.rdata[STAT_SRC_BIT]   = s_reg.src_xtal;
                s_next.rdata[STAT_FAIL_BIT]  = s_reg.fail_flag;
                s_next.rdata[STAT_FLASH_BIT] = s_reg.flash_act;
            end
            else if (bus.addr == ADDR_REF_DIV)
            begin
                s_next.rdata[15:0] = s_reg.ref_inc;
            end
            else if (bus.addr == ADDR_WDOG_CTRL)
            begin
                s_next.rdata[WDOG_EN_BIT] = s_reg.wd_en;
            end
            else if (bus.addr == ADDR_WDOG_COUNT)
            begin
                s_next.rdata[11:0] = wd_count;
            end
            else if (bus.addr == ADDR_SLP_CTRL)
            begin
                s_next.rdata[SLP_SRC_BIT]       = s_reg.st_src;
                s_next.rdata[SLP_EXP_LSB +: 4]  = s_reg.st_exp;
                s_next.rdata[SLP_DBG_BIT]       = s_reg.st_dbg;
                s_next.rdata[SLP_IRQ_LSB +: 3]  = s_reg.st_irq_en;
                s_next.rdata[SLP_WAKE_LSB +: 3] = s_reg.st_wake_en;
            end
            else if (bus.addr == ADDR_SLP_COUNT)
            begin
                s_next.rdata = s_reg.st_cnt;
            end
            else if (bus.addr == ADDR_SLP_CMP_A)
            begin
                s_next.rdata = s_reg.cmp_a;
            end
            else if (bus.addr == ADDR_SLP_CMP_B)
            begin
                s_next.rdata = s_reg.cmp_b;
            end
        end

        // Main clock divider phase and switchover
        if (main_en)
        begin
            s_next.phase = ~s_reg.phase;
        end
        if (boundary)
        begin
            s_next.src_xtal     = s_reg.sel_xtal;
            s_next.cpu_fast_act = s_reg.cpu_fast;
            s_next.flash_act    = flash_busy;
        end

        // Crystal watchdog: no edge within the timeout means dead crystal
        if (!s_reg.src_xtal || osc.fast_xtal)
        begin
            s_next.fail_cnt = '0;
        end
        else if (s_reg.fail_cnt == 8'(XTAL_TIMEOUT_CYC - 1))
        begin
            s_next.fail_cnt  = '0;
            s_next.src_xtal  = 1'b0;
            s_next.sel_xtal  = 1'b0;
            s_next.phase     = 1'b0;
            s_next.fail_flag = 1'b1;
            s_next.nmi_fail  = 1'b1;
        end
        else
        begin
            s_next.fail_cnt = s_reg.fail_cnt + 8'h01;
        end

        // Fractional-N reference divider
        if (rc_tick)
        begin
            s_next.ref_acc  = ref_sum[15:0];
            s_next.ref_tick = ref_sum[16];
        end

        // Sleep timer prescaler and counter
        if (st_src_tick && st_run)
        begin
            s_next.st_pre = s_reg.st_pre + 16'h0001;
            if ((s_reg.st_pre & pre_mask(s_reg.st_exp)) == pre_mask(s_reg.st_exp))
            begin
                s_next.st_tick = 1'b1;
                s_next.st_cnt  = st_inc;
                s_next.st_irq  = |(st_ev & s_reg.st_irq_en);
                s_next.st_wake = |(st_ev & s_reg.st_wake_en);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            s_reg          <= '0;
            s_reg.bias     <= BIAS_RST;
            s_reg.ref_inc  <= REF_INC_RST;
            s_reg.st_exp   <= SLP_EXP_RST;
            s_reg.src_xtal <= 1'b0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog

    csst_wdog #(
        .CNT_W (12)
    ) u_wdog (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .tick       (s_reg.ref_tick),
        .enable     (s_reg.wd_en),
        .restart    (s_reg.wd_restart),
        .dbg_halt   (dbg_halt),
        .count      (wd_count),
        .warn_nmi   (wdog_warn_nmi),
        .wdog_reset (wdog_reset)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign clk_out.main_clock          = main_en;
    assign clk_out.periph_clock        = periph_en;
    assign clk_out.cpu_core_clock      = cpu_en;
    assign clk_out.reference_tick_1khz = s_reg.ref_tick;
    assign clk_out.sleep_tick          = s_reg.st_tick;
    assign clk_out.event_tick_timer    = s_reg.evt_sel ? s_reg.st_tick : cpu_en;
    assign crystal_bias = s_reg.bias;
    assign failover_nmi = s_reg.nmi_fail;
    assign sleep_irq    = s_reg.st_irq;
    assign sleep_wake   = s_reg.st_wake;
    assign rdata        = s_reg.rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    chk_fail_switch: assert property (@(posedge clk) disable iff (sys_rst)
        s_reg.src_xtal && !osc.fast_xtal
            && s_reg.fail_cnt == 8'(XTAL_TIMEOUT_CYC - 1)
        |=> !s_reg.src_xtal && !s_reg.sel_xtal && s_reg.fail_flag)
        else $error("no failover on dead crystal");

    chk_fail_nmi: assert property (@(posedge clk) disable iff (sys_rst)
        failover_nmi |-> $past(s_reg.src_xtal) && !s_reg.src_xtal ##1 !failover_nmi)
        else $error("failover interrupt without failover");

    chk_reset_rc: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(sys_rst) |-> !s_reg.src_xtal && !s_reg.wd_en)
        else $error("crystal selected after reset");

    chk_periph_half: assert property (@(posedge clk) disable iff (sys_rst)
        periph_en |-> main_en && s_reg.phase ##1 !s_reg.phase)
        else $error("peripheral clock not half rate");

    chk_cpu_fast: assert property (@(posedge clk) disable iff (sys_rst)
        !s_reg.flash_act && s_reg.cpu_fast_act |-> cpu_en == main_en)
        else $error("fast cpu clock not main clock");

    chk_flash_cpu: assert property (@(posedge clk) disable iff (sys_rst)
        s_reg.flash_act |-> cpu_en == (s_reg.src_xtal ? periph_en : main_en))
        else $error("cpu clock not forced during flash");

    chk_switch_edge: assert property (@(posedge clk) disable iff (sys_rst)
        $changed(s_reg.src_xtal) |-> !s_reg.phase && (failover_nmi || !$past(s_reg.phase)))
        else $error("source switched mid period");

    chk_st_pause: assert property (@(posedge clk) disable iff (sys_rst)
        dbg_halt && s_reg.st_dbg |=> $stable(s_reg.st_cnt))
        else $error("sleep timer moved while paused");

    chk_ref_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        s_reg.ref_tick |-> $past(rc_tick) ##1 !s_reg.ref_tick)
        else $error("reference tick without slow edge");

endmodule

/* dv/csst_osc_model.sv */
// Oscillator pulse source standing in for the clock sources
module csst_osc_model (
    input  wire logic             clk,
    input  wire logic             xtal_stop,
    output csst_pkg::csst_osc_type osc
);
    timeunit 1ns;
    timeprecision 1ps;
    import csst_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    int unsigned cyc = 0;

    initial osc = '0;

    // Fast ratio kept at 2:1; slow rates sped up to keep the run short
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        osc.fast_rc <= (cyc % 4) == 0;
        osc.fast_xtal <= !xtal_stop && (cyc % 2) == 1;
        osc.slow_rc <= (cyc % 4) == 2;
        osc.slow_xtal <= (cyc % 6) == 3;
        osc.slow_pin <= (cyc % 10) == 5;
    end
endmodule

/* dv/csst_top_tb_top.sv */
// Self-checking bench for the clock switch and system timers
module csst_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import csst_pkg::*;

    localparam int SX = 1, SP = 0, EV = 5, SL = 6, RT = 7, CP = 8, PE = 9, MN = 10;
    localparam int IQ = 11, XR = 12, WN = 13, FO = 14, NV = 15, WK = 16;
    logic         clk         = 1'b0;
    logic         sys_rst     = 1'b1;
    csst_bus_type bus         = '0;
    logic         flash_busy  = 1'b0;
    logic         dbg_halt    = 1'b0;
    logic         slow_rc_off = 1'b0;
    logic         xtal_stop   = 1'b0;
    logic [31:0]  rdata;
    csst_osc_type osc;
    csst_clk_type ck;
    logic [3:0]   bias;
    logic         fo_nmi;
    logic         warn_nmi;
    logic         wd_rst;
    logic         irq;
    logic         wake;
    logic [16:0]  mon;
    int           error_cnt   = 0;
    int           n_tests     = 0;

    // One vector so counting tasks can pick any pulse by index
    assign mon = {wake, 1'b0, fo_nmi, warn_nmi, wd_rst, irq, ck, osc};
    always #2 clk = ~clk;

    csst_osc_model u_csst_osc_model (.clk(clk), .xtal_stop(xtal_stop), .osc(osc));
    csst_top u_csst_top (.clk(clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata), .osc(osc),
        .flash_busy(flash_busy), .dbg_halt(dbg_halt), .slow_rc_off(slow_rc_off),
        .clk_out(ck), .crystal_bias(bias), .failover_nmi(fo_nmi), .wdog_warn_nmi(warn_nmi),
        .wdog_reset(wd_rst), .sleep_irq(irq), .sleep_wake(wake));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic wait_on(int s);
        int j = 0;
        do
        begin
            @(posedge clk);
            #1;
            j++;
        end
        while (mon[s] !== 1'b1 && j < 4000);
    endtask

    // Counts pulses of c until s pulses; wd leaves out halted cycles
    task automatic cnt_until(int c, int s, int lim, bit wd, output int k);
        k = 0;
        for (int j = 0; j < lim; j++)
        begin
            @(posedge clk);
            #1;
            if (mon[s] === 1'b1)
                break;
            if (mon[c] === 1'b1 && !(wd && dbg_halt))
                k++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] d;
        rd(ADDR_CLK_CTRL, d);
        check("ctrl", d, 32'h0000_00F0);
        rd(ADDR_CLK_STATUS, d);
        check("status", d, 32'h0);
        rd(ADDR_REF_DIV, d);
        check("refdiv", d, 32'h0000_199A);
        rd(8'h40, d);
        check("unmapped", d, 32'h0);
        check("bias", bias, 4'hF);
        wr(ADDR_CLK_CTRL, 32'h0000_0030);
        @(negedge clk);
        check("bias", bias, 4'h3);
    endtask

    task automatic t_modes();
        int n;
        int m;
        for (int i = 0; i < 8; i++)
        begin
            m = i[0] ? 20 : 10;
            wr(ADDR_CLK_CTRL, 32'h0000_00F0 | 32'(i & 3));
            flash_busy <= i[2];
            repeat (16) @(posedge clk);
            cnt_until(MN, NV, 40, 0, n);
            check("main", n, m);
            cnt_until(PE, NV, 40, 0, n);
            check("periph", n, m / 2);
            cnt_until(CP, NV, 40, 0, n);
            if (i[2])
                check("cpu", n, 10);
            else
                check("cpu", n, i[1] ? m : m / 2);
        end
        @(posedge clk);
        flash_busy <= 1'b0;
    endtask

    task automatic t_failover();
        logic [31:0] d;
        int n;
        wr(ADDR_CLK_CTRL, 32'h0000_00F1);
        repeat (16) @(posedge clk);
        xtal_stop <= 1'b1;
        wait_on(FO);
        check("nmi", fo_nmi, 1'b1);
        rd(ADDR_CLK_STATUS, d);
        check("status", d[1:0], 2'h2);
        rd(ADDR_CLK_CTRL, d);
        check("select", d[0], 1'b0);
        cnt_until(MN, NV, 40, 0, n);
        check("main", n, 10);
        @(posedge clk);
        xtal_stop <= 1'b0;
        wr(ADDR_CLK_STATUS, 32'h0000_0002);
        rd(ADDR_CLK_STATUS, d);
        check("cleared", d[1], 1'b0);
    endtask

    task automatic t_wdog();
        logic [31:0] d;
        int n;
        wr(ADDR_REF_DIV, 32'h0000_8000);
        repeat (16) @(posedge clk);
        cnt_until(RT, NV, 80, 0, n);
        check("ref", n, 10);
        rd(ADDR_WDOG_COUNT, d);
        check("idle", d, 32'h0);
        wait_on(RT);
        wr(ADDR_WDOG_CTRL, 32'h0000_0001);
        repeat (8000) @(posedge clk);
        // Writes land right after a tick so none races the restart
        wait_on(RT);
        wr(ADDR_WDOG_CTRL, 32'h0000_0003);
        fork
            begin
                repeat (800) @(posedge clk);
                dbg_halt <= 1'b1;
                repeat (3200) @(posedge clk);
                dbg_halt <= 1'b0;
            end
        join_none
        cnt_until(RT, WN, 40000, 1, n);
        check("warn", n, 1792);
        cnt_until(RT, XR, 4000, 1, n);
        check("expire", n, 256);
        wr(ADDR_WDOG_CTRL, 32'h0);
    endtask

    task automatic t_sleep();
        logic [31:0] d;
        logic [31:0] e;
        int n;
        wr(ADDR_SLP_CTRL, 32'h0000_1020);
        wait_on(SL);
        cnt_until(RT, SL, 2000, 0, n);
        check("prescale", n, 4);
        @(posedge clk);
        dbg_halt <= 1'b1;
        wait_on(SL);
        cnt_until(RT, SL, 2000, 0, n);
        check("halted", n, 4);
        // Optional pause on halt: no sleep tick while still halted
        wr(ADDR_SLP_CTRL, 32'h0000_1120);
        cnt_until(SL, NV, 200, 0, n);
        check("paused", n, 0);
        @(posedge clk);
        dbg_halt <= 1'b0;
        rd(ADDR_SLP_COUNT, d);
        wr(ADDR_SLP_CMP_A, d + 32'h3);
        wait_on(IQ);
        check("irq", irq, 1'b1);
        rd(ADDR_SLP_COUNT, e);
        check("cmp", e, d + 32'h3);
        wr(ADDR_SLP_CTRL, 32'h0002_0020);
        rd(ADDR_SLP_COUNT, d);
        wr(ADDR_SLP_CMP_B, d + 32'h2);
        wait_on(WK);
        check("wake", wake, 1'b1);
        wr(ADDR_SLP_CTRL, 32'h0000_0011);
        wait_on(SL);
        cnt_until(SX, SL, 2000, 0, n);
        check("xtal", n, 2);
        wr(ADDR_CLK_CTRL, 32'h0000_01F0);
        wait_on(SL);
        cnt_until(SP, SL, 2000, 0, n);
        check("pin", n, 2);
        wr(ADDR_SLP_CTRL, 32'h0000_0020);
        slow_rc_off <= 1'b1;
        repeat (40) @(posedge clk);
        cnt_until(SL, NV, 400, 0, n);
        check("stopped", n, 0);
        @(posedge clk);
        slow_rc_off <= 1'b0;
    endtask

    task automatic t_evt();
        int n;
        for (int i = 0; i < 2; i++)
        begin
            wr(ADDR_CLK_CTRL, i ? 32'h0000_02F0 : 32'h0000_00F0);
            repeat (8) @(posedge clk);
            n = 0;
            repeat (64)
            begin
                @(posedge clk);
                #1;
                n += int'(mon[EV] !== mon[i ? SL : CP]);
            end
            check("event", n, 0);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #200us;
        error_cnt++;
        end_sim();
    end

    initial
    begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_modes();
        t_failover();
        t_wdog();
        t_sleep();
        t_evt();
        end_sim();
    end
endmodule
